//--- rtl/usb_sie_pkg.sv
// Constants shared by the status and endpoint-control block and its queue memory.
// Assumes an 8-bit CPU register port with a 12-bit data address.
package usb_sie_pkg;
   // Register addresses on the CPU data space
   localparam logic [11:0] STATUS_OFS = 12'hF64;
   localparam logic [11:0] EP_CTRL_BASE_OFS = 12'hF70;
   localparam logic [11:0] DEV_ADDR_OFS = 12'hF80;
   localparam logic [11:0] FRAME_LOW_OFS = 12'hF82;
   localparam logic [11:0] FRAME_HIGH_OFS = 12'hF83;
   // Shared USB RAM map
   localparam logic [11:0] RAM_LAST = 12'hEBF;
   localparam logic [11:0] BD_FIRST = 12'hD00;
   localparam logic [11:0] BD_LAST = 12'hDFF;
   // Endpoint control field positions
   localparam int EPC_HSHK = 4;
   localparam int EPC_CONDIS = 3;
   localparam int EPC_OUTEN = 2;
   localparam int EPC_INEN = 1;
   localparam int EPC_STALL = 0;
   localparam logic [4:0] EPC_RST = 5'h00;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [10:0] FRAME_RST = 11'h000;
   // Status entry layout inside the status register
   localparam int STAT_EP_LSB = 3;
   localparam int STAT_DIR_BIT = 2;
   localparam int STAT_ODD_BIT = 1;
   localparam int ENTRY_W = 6;
   localparam int QUEUE_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] QUEUE_FULL = 3'h4;
   localparam int EP_COUNT = 16;
   // Flag reassert limit: 5 instruction cycles of 62.5 ns, rounded down
   localparam int TCY_PS = 62500;
   localparam int CLK_PS = 8000;
   localparam int RELOAD_TCY = 5;
   localparam int RELOAD_CYCLES = RELOAD_TCY * TCY_PS / CLK_PS;
   // Token kinds from the packet decoder
   localparam logic [1:0] TOK_OUT = 2'h0;
   localparam logic [1:0] TOK_IN = 2'h1;
   localparam logic [1:0] TOK_SETUP = 2'h2;
   // Answer to the host for one token
   typedef enum logic [1:0] {
      RESP_NONE = 2'h0,
      RESP_ACCEPT = 2'h1,
      RESP_NAK = 2'h2,
      RESP_STALL = 2'h3
   } resp_e;
endpackage

//--- rtl/status_queue_mem.sv
// Small storage array for the transfer status queue.
// Assumes one writer and one reader per clock; read data is registered.
module status_queue_mem
   import usb_sie_pkg::*;
#(
   parameter int W = ENTRY_W,
   parameter int D = QUEUE_DEPTH,
   parameter int AW = PTR_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem_r [D];

   // Storage carries no reset; contents are meaningless until written
   always_ff @(posedge mclk) begin
      if (ce && wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // Registered read port follows the head pointer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule // status_queue_mem

//--- rtl/usb_sie_status_endpoint_ctrl.sv
// Status queue, endpoint control, device address and frame number of the USB engine.
// Assumes engine events and CPU accesses are synchronous single-cycle pulses on mclk.
module usb_sie_status_endpoint_ctrl
   import usb_sie_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [11:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   input wire logic transfer_done_clear,
   output logic transfer_done_flag,
   input wire logic tok_valid,
   input wire logic [3:0] tok_ep,
   input wire logic [1:0] tok_pid,
   input wire logic tok_bd_stall,
   output logic resp_valid,
   output logic [1:0] resp_code,
   output logic resp_handshake,
   input wire logic xfer_done,
   input wire logic [3:0] xfer_ep,
   input wire logic xfer_dir,
   input wire logic xfer_odd,
   input wire logic [5:0] xfer_bd_index,
   output logic desc_release,
   output logic [5:0] desc_release_index,
   input wire logic bus_reset_flag,
   output logic [6:0] device_bus_address,
   input wire logic sof_valid,
   input wire logic [10:0] sof_frame,
   input wire logic suspend_control,
   output logic frame_valid,
   output logic usb_ram_hit,
   output logic bd_bank_hit
);
   localparam int RELOAD_MAX = RELOAD_CYCLES;

   logic [PTR_W-1:0] head_r;
   logic [PTR_W-1:0] tail_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic transfer_done_flag_r;
   logic [ENTRY_W-1:0] head_entry;
   logic [4:0] ep_ctrl_r [EP_COUNT];
   logic [6:0] addr_r;
   logic [10:0] frame_r;
   logic push;
   logic pop;
   logic full;
   logic [4:0] tok_ctl;
   logic tok_allowed;
   resp_e resp_nxt;
   logic stall_now;
   logic ep_hit;
   logic [3:0] ep_sel;

   assign full = (count_r == QUEUE_FULL);
   // A completion that arrives while the queue is full is dropped, not queued
   assign push = xfer_done && !full;
   assign pop = transfer_done_clear && transfer_done_flag_r && (count_r != '0);
   assign ep_hit = (cpu_addr[11:4] == EP_CTRL_BASE_OFS[11:4]);
   assign ep_sel = cpu_addr[3:0];

   // Queue occupancy after this cycle's push and pop
   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + 3'h1;
      end else if (pop && !push) begin
         count_nxt = count_r - 3'h1;
      end
   end

   // Status storage, head entry read back through a register
   status_queue_mem #(
      .W(ENTRY_W),
      .D(QUEUE_DEPTH),
      .AW(PTR_W)
   ) u_queue (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .wr_en(push),
      .wr_addr(tail_r),
      .wr_data({xfer_ep, xfer_dir, xfer_odd}),
      .rd_addr(head_r),
      .rd_data(head_entry)
   );

   // Pointers and count; completion order is preserved
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         head_r <= '0;
         tail_r <= '0;
         count_r <= '0;
      end else if (ce) begin
         if (push) begin
            tail_r <= tail_r + 2'h1;
         end
         if (pop) begin
            head_r <= head_r + 2'h1;
         end
         count_r <= count_nxt;
      end
   end

   // Flag drops for the pop cycle, then follows head validity; a push never gets lost
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         transfer_done_flag_r <= 1'b0;
      end else if (ce) begin
         if (pop) begin
            transfer_done_flag_r <= 1'b0;
         end else begin
            transfer_done_flag_r <= (count_r != '0);
         end
      end
   end
   assign transfer_done_flag = transfer_done_flag_r;

   // Token decode against the endpoint's enables
   always_comb begin
      tok_ctl = ep_ctrl_r[tok_ep];
      tok_allowed = 1'b0;
      unique case (tok_pid)
         TOK_OUT: tok_allowed = tok_ctl[EPC_OUTEN];
         TOK_IN: tok_allowed = tok_ctl[EPC_INEN];
         TOK_SETUP: tok_allowed = tok_ctl[EPC_OUTEN] && tok_ctl[EPC_INEN] && !tok_ctl[EPC_CONDIS];
         default: tok_allowed = 1'b0;
      endcase
      if (!tok_allowed) begin
         resp_nxt = RESP_NONE;
      end else if (full) begin
         resp_nxt = RESP_NAK;
      end else if (tok_bd_stall) begin
         resp_nxt = RESP_STALL;
      end else begin
         resp_nxt = RESP_ACCEPT;
      end
   end
   assign stall_now = tok_valid && (resp_nxt == RESP_STALL);

   // Answer to the packet engine, one pulse per token
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_code <= RESP_NONE;
         resp_handshake <= 1'b0;
      end else if (ce) begin
         resp_valid <= tok_valid;
         if (tok_valid) begin
            resp_code <= resp_nxt;
            resp_handshake <= tok_ctl[EPC_HSHK];
         end
      end
   end

   // Endpoint control registers; a STALL sent in the same cycle beats a firmware clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < EP_COUNT; i++) begin
            ep_ctrl_r[i] <= EPC_RST;
         end
      end else if (ce) begin
         for (int i = 0; i < EP_COUNT; i++) begin
            if (cpu_wr && ep_hit && (ep_sel == 4'(i))) begin
               ep_ctrl_r[i] <= cpu_wdata[4:0];
            end
            if (stall_now && (tok_ep == 4'(i))) begin
               ep_ctrl_r[i][EPC_STALL] <= 1'b1;
            end
         end
      end
   end

   // Device address; bus reset wins over a firmware write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= ADDR_RST;
      end else if (ce) begin
         if (bus_reset_flag) begin
            addr_r <= ADDR_RST;
         end else if (cpu_wr && (cpu_addr == DEV_ADDR_OFS)) begin
            addr_r <= cpu_wdata[6:0];
         end
      end
   end
   assign device_bus_address = addr_r;

   // Frame number latched on SOF; suspend only clears frame_valid, an SOF still loads the frame number
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_r <= FRAME_RST;
         frame_valid <= 1'b0;
      end else if (ce) begin
         if (sof_valid) begin
            frame_r <= sof_frame;
         end
         frame_valid <= !suspend_control;
      end
   end

   // Descriptor handed back to the CPU once its transaction is done
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         desc_release <= 1'b0;
         desc_release_index <= '0;
      end else if (ce) begin
         desc_release <= xfer_done;
         if (xfer_done) begin
            desc_release_index <= xfer_bd_index;
         end
      end
   end

   // RAM region decode for every CPU access
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         usb_ram_hit <= 1'b0;
         bd_bank_hit <= 1'b0;
      end else if (ce) begin
         usb_ram_hit <= (cpu_rd || cpu_wr) && (cpu_addr <= RAM_LAST);
         bd_bank_hit <= (cpu_rd || cpu_wr) && (cpu_addr >= BD_FIRST) && (cpu_addr <= BD_LAST);
      end
   end

   // Read mux; status writes fall through with no effect
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata <= 8'h00;
      end else if (ce && cpu_rd) begin
         if (cpu_addr == STATUS_OFS) begin
            cpu_rdata <= {1'b0, head_entry, 1'b0};
         end else if (ep_hit) begin
            cpu_rdata <= {3'h0, ep_ctrl_r[ep_sel]};
         end else if (cpu_addr == DEV_ADDR_OFS) begin
            cpu_rdata <= {1'b0, addr_r};
         end else if (cpu_addr == FRAME_LOW_OFS) begin
            cpu_rdata <= frame_r[7:0];
         end else if (cpu_addr == FRAME_HIGH_OFS) begin
            cpu_rdata <= {5'h00, frame_r[10:8]};
         end else begin
            cpu_rdata <= 8'h00;
         end
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n || !ce);

   flag_reassert_a: assert property (pop && count_r > 3'h1 |-> ##[1:RELOAD_MAX] transfer_done_flag)
      else $error("flag not reasserted after pop");
   flag_stays_clear_a: assert property (pop && count_r == 3'h1 && !push |=> !transfer_done_flag[*2])
      else $error("flag set with empty queue");
   queue_grows_a: assert property (push && !pop |=> count_r == $past(count_r) + 3'h1)
      else $error("push lost");
   full_nak_a: assert property (tok_valid && full && tok_allowed |=> resp_valid && resp_code == RESP_NAK)
      else $error("no NAK when full");
   setup_reject_a: assert property (tok_valid && tok_pid == TOK_SETUP && tok_ctl[EPC_CONDIS]
      |=> resp_code == RESP_NONE)
      else $error("SETUP accepted while disabled");
   stall_marks_a: assert property (stall_now |=> ep_ctrl_r[$past(tok_ep)][EPC_STALL])
      else $error("stall bit not set");
   addr_clear_a: assert property (bus_reset_flag |=> device_bus_address == ADDR_RST)
      else $error("address not cleared");
   frame_load_a: assert property (sof_valid |=> frame_r == $past(sof_frame))
      else $error("frame number not loaded");
   status_pad_a: assert property (cpu_rd && cpu_addr == STATUS_OFS
      |=> cpu_rdata[7] == 1'b0 && cpu_rdata[0] == 1'b0)
      else $error("status pad bits set");
   status_head_a: assert property (transfer_done_flag && cpu_rd && cpu_addr == STATUS_OFS
      |=> cpu_rdata[6:1] == $past(head_entry))
      else $error("status not head entry");
   release_a: assert property (xfer_done |=> desc_release && desc_release_index == $past(xfer_bd_index))
      else $error("descriptor not released");

   // Flag tracks head validity outside the pop cycle
   flag_follows_a: assert property (!pop && count_r != 3'h0 |=> transfer_done_flag)
      else $error("flag missing with entries queued");
   flag_empty_a: assert property (count_r == 3'h0 |=> !transfer_done_flag)
      else $error("flag set on empty queue");
   clear_ignored_a: assert property (transfer_done_clear && !transfer_done_flag && !push
      |=> count_r == $past(count_r))
      else $error("clear without flag popped");
   // A full queue must never move the write pointer onto the head
   tail_hold_a: assert property (full |=> tail_r == $past(tail_r))
      else $error("tail moved while full");
   tail_step_a: assert property (push |=> tail_r == $past(tail_r) + 2'h1)
      else $error("tail did not advance");
   // Disabled directions are ignored rather than answered
   in_reject_a: assert property (tok_valid && tok_pid == TOK_IN && !tok_ctl[EPC_INEN]
      |=> resp_code == RESP_NONE)
      else $error("IN answered while disabled");
   out_reject_a: assert property (tok_valid && tok_pid == TOK_OUT && !tok_ctl[EPC_OUTEN]
      |=> resp_code == RESP_NONE)
      else $error("OUT answered while disabled");
   handshake_a: assert property (tok_valid |=> resp_handshake == $past(tok_ctl[EPC_HSHK]))
      else $error("handshake enable not reported");
   // Stall indicator only drops on a firmware write
   stall_hold_a: assert property (ep_ctrl_r[0][EPC_STALL] && !(cpu_wr && ep_hit && ep_sel == 4'h0)
      |=> ep_ctrl_r[0][EPC_STALL])
      else $error("stall bit lost");
   ram_miss_a: assert property ((cpu_rd || cpu_wr) && cpu_addr > RAM_LAST |=> !usb_ram_hit)
      else $error("access beyond USB RAM flagged");
   bd_bank_a: assert property ((cpu_rd || cpu_wr) && cpu_addr >= BD_FIRST && cpu_addr <= BD_LAST
      |=> bd_bank_hit && usb_ram_hit)
      else $error("descriptor bank access missed");
   suspend_a: assert property (suspend_control |=> !frame_valid)
      else $error("frame marked valid in suspend");

   queue_full_c: cover property (full ##1 pop);
   stall_sent_c: cover property (stall_now);
   back_to_back_c: cover property (push ##1 push ##1 pop);
   sof_load_c: cover property (sof_valid && frame_valid);
endmodule // usb_sie_status_endpoint_ctrl

//--- tb/usb_host_model.sv
// Host side model: sends tokens and SOF frame numbers to the engine.
// Assumes callers run in a process synced to mclk; all drives land on rising edges.
module usb_host_model (
   input wire logic mclk,
   output logic tok_valid,
   output logic [3:0] tok_ep,
   output logic [1:0] tok_pid,
   output logic tok_bd_stall,
   output logic sof_valid,
   output logic [10:0] sof_frame
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial {tok_valid, tok_ep, tok_pid, tok_bd_stall, sof_valid, sof_frame} = '0;
   // One token pulse; fields are inverted after it so stale values never look valid
   task automatic token(input logic [3:0] ep, input logic [1:0] pid, input logic stl);
      @(posedge mclk);
      tok_valid <= 1'b1;
      tok_ep <= ep;
      tok_pid <= pid;
      tok_bd_stall <= stl;
      @(posedge mclk);
      tok_valid <= 1'b0;
      tok_ep <= ~ep;
      tok_pid <= ~pid;
      tok_bd_stall <= ~stl;
   endtask
   // SOF pulse carrying the 11-bit frame number
   task automatic sof(input logic [10:0] f);
      @(posedge mclk);
      sof_valid <= 1'b1;
      sof_frame <= f;
      @(posedge mclk);
      sof_valid <= 1'b0;
      sof_frame <= ~f;
   endtask
endmodule // usb_host_model

//--- tb/usb_sie_status_endpoint_ctrl_bench.sv
// Self-checking bench for the status queue, endpoint control, address and frame number.
// Assumes the package and host model compile first; inputs change only on mclk rising edges.
module usb_sie_status_endpoint_ctrl_bench
   import usb_sie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, ce, cpu_wr, cpu_rd, transfer_done_clear, xfer_done, xfer_dir, xfer_odd;
   logic bus_reset_flag, suspend_control, tok_valid, tok_bd_stall, sof_valid, transfer_done_flag;
   logic resp_valid, resp_handshake, desc_release, frame_valid, usb_ram_hit, bd_bank_hit;
   logic [11:0] cpu_addr;
   logic [7:0] cpu_wdata, cpu_rdata, d;
   logic [3:0] tok_ep, xfer_ep;
   logic [1:0] tok_pid, resp_code;
   logic [5:0] xfer_bd_index, desc_release_index;
   logic [6:0] device_bus_address;
   logic [10:0] sof_frame;
   logic [11:0] ram_a[6] = '{12'h000, 12'hCFF, 12'hD00, 12'hDFF, 12'hEBF, 12'hEC0};
   int n_mismatch = 0, n_checks = 0, cyc = 0, ep_m[16], q[$], e, i, k;

   usb_sie_status_endpoint_ctrl DUT (.mclk, .rst_n, .ce, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
      .cpu_rdata, .transfer_done_clear, .transfer_done_flag, .tok_valid, .tok_ep, .tok_pid,
      .tok_bd_stall, .resp_valid, .resp_code, .resp_handshake, .xfer_done, .xfer_ep, .xfer_dir,
      .xfer_odd, .xfer_bd_index, .desc_release, .desc_release_index, .bus_reset_flag,
      .device_bus_address, .sof_valid, .sof_frame, .suspend_control, .frame_valid, .usb_ram_hit,
      .bd_bank_hit);
   usb_host_model host (.mclk, .tok_valid, .tok_ep, .tok_pid, .tok_bd_stall, .sof_valid, .sof_frame);

   // Free-running 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Cycle ceiling far above the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Four-state compare, so an unknown never passes
   task automatic chk(input logic [10:0] got, input int exp, input string what);
      n_checks++;
      if (got !== 11'(exp)) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   // Register port cycles: strobe for one edge, read data taken just after the next
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_wdata <= v;
      cpu_wr <= 1'b1;
      @(posedge mclk);
      cpu_wr <= 1'b0;
      cpu_wdata <= ~v;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge mclk);
      cpu_rd <= 1'b0;
      #1 d = cpu_rdata;
   endtask
   // Token through the host, answer predicted from the endpoint model
   task automatic tok(input logic [3:0] ep, input logic [1:0] pid, input logic stl, input bit full);
      int c, ok;
      c = ep_m[ep];
      ok = pid == TOK_OUT ? c[2] : pid == TOK_IN ? c[1] : c[2] & c[1] & !c[3];
      e = !ok ? 0 : full ? 2 : stl ? 3 : 1;
      host.token(ep, pid, stl);
      #1 chk(resp_valid, 1, "resp valid");
      chk(resp_code, e, "resp code");
      chk(resp_handshake, c[4], "handshake");
      if (e == 3) ep_m[ep] |= 1;
   endtask
   // Completions on consecutive edges; those beyond four are dropped by the engine
   task automatic burst(input int n);
      int ep, dr, od, bi, pb;
      for (k = 0; k <= n; k++) begin
         ep = $urandom_range(15);
         dr = $urandom_range(1);
         od = $urandom_range(1);
         bi = $urandom_range(63);
         @(posedge mclk);
         xfer_done <= k < n;
         xfer_ep <= 4'(ep);
         xfer_dir <= dr[0];
         xfer_odd <= od[0];
         xfer_bd_index <= 6'(bi);
         if (k < n && q.size() < QUEUE_DEPTH) q.push_back(ep * 8 + dr * 4 + od * 2);
         #1;
         if (k > 0) begin
            chk(desc_release, 1, "release");
            chk(desc_release_index, pb, "release index");
         end
         pb = bi;
      end
   endtask
   // Pop in order; the flag must return within the reload limit while entries remain
   task automatic drain();
      while (q.size() > 0) begin
         for (k = 0; k < RELOAD_CYCLES && transfer_done_flag !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
         end
         chk(transfer_done_flag, 1, "flag");
         rd(STATUS_OFS);
         chk(d, q.pop_front(), "status");
         @(posedge mclk);
         transfer_done_clear <= 1'b1;
         @(posedge mclk);
         transfer_done_clear <= 1'b0;
         #1;
      end
      repeat (RELOAD_CYCLES + 4) @(posedge mclk);
      // Stray clear on an empty queue must change nothing
      transfer_done_clear <= 1'b1;
      @(posedge mclk);
      transfer_done_clear <= 1'b0;
      #1 chk(transfer_done_flag, 0, "flag empty");
   endtask

   // Main sequence
   initial begin
      {rst_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, transfer_done_clear, xfer_done, bus_reset_flag} = '0;
      {xfer_ep, xfer_dir, xfer_odd, xfer_bd_index, suspend_control} = '0;
      ce = 1'b1;
      void'($urandom(32'h04C3));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < EP_COUNT; i++) begin
         rd(EP_CTRL_BASE_OFS + 12'(i));
         chk(d, 0, "ctrl reset");
      end
      rd(DEV_ADDR_OFS);
      chk(d, 0, "addr reset");
      // Random control bytes, then every token kind with random descriptor stalls
      for (i = 0; i < EP_COUNT; i++) begin
         e = $urandom_range(255);
         if (i == 0) e = e & 'hF7;
         wr(EP_CTRL_BASE_OFS + 12'(i), 8'(e));
         ep_m[i] = e & 'h1F;
         rd(EP_CTRL_BASE_OFS + 12'(i));
         chk(d, ep_m[i], "ctrl rw");
         for (k = 0; k < 3; k++) tok(4'(i), 2'(k), 1'($urandom_range(1)), 0);
         rd(EP_CTRL_BASE_OFS + 12'(i));
         chk(d, ep_m[i], "stall bit");
      end
      // Firmware clears the stall, then the queue overflows and the host is refused
      wr(EP_CTRL_BASE_OFS + 12'h001, 8'h16);
      ep_m[1] = 'h16;
      rd(EP_CTRL_BASE_OFS + 12'h001);
      chk(d, 'h16, "stall cleared");
      wr(STATUS_OFS, 8'hFF);
      burst(QUEUE_DEPTH + 1);
      tok(4'h1, TOK_IN, 1'b1, q.size() == QUEUE_DEPTH);
      drain();
      burst(2);
      drain();
      // Address load, then a bus reset returns it to zero
      e = $urandom_range(127);
      wr(DEV_ADDR_OFS, 8'(e));
      rd(DEV_ADDR_OFS);
      chk(d, e, "addr");
      chk(device_bus_address, e, "addr port");
      @(posedge mclk);
      bus_reset_flag <= 1'b1;
      @(posedge mclk);
      bus_reset_flag <= 1'b0;
      #1 chk(device_bus_address, 0, "addr bus reset");
      // Frame number from SOF, read-only to the CPU
      e = $urandom_range(2047);
      host.sof(11'(e));
      wr(FRAME_LOW_OFS, 8'hA5);
      rd(FRAME_LOW_OFS);
      chk(d, e % 256, "frame low");
      rd(FRAME_HIGH_OFS);
      chk(d, e / 256, "frame high");
      // Frozen engine must ignore an SOF
      @(posedge mclk);
      ce <= 1'b0;
      host.sof(11'(e + 1));
      ce <= 1'b1;
      rd(FRAME_LOW_OFS);
      chk(d, e % 256, "frame frozen");
      chk(frame_valid, 1, "frame valid");
      @(posedge mclk);
      suspend_control <= 1'b1;
      @(posedge mclk);
      #1 chk(frame_valid, 0, "suspend");
      // RAM window edges; reads only, so no engine-owned buffer is disturbed
      foreach (ram_a[j]) begin
         rd(ram_a[j]);
         chk(usb_ram_hit, ram_a[j] <= RAM_LAST, "ram hit");
         chk(bd_bank_hit, ram_a[j] >= BD_FIRST && ram_a[j] <= BD_LAST, "bd hit");
      end
      chk(d, 0, "unmapped");
      wrap_up();
   end
endmodule // usb_sie_status_endpoint_ctrl_bench
